// File: core/mode_reg_pkg.sv
/*
 * Shared constants for the mode register two/three configuration link.
 * Assumes both ends share one clock and meet in mode_link_if.
 */
package mode_reg_pkg;
    // ------------------------------------------------------------------
    // Command and address field layout
    // ------------------------------------------------------------------
    localparam int ADDR_W              = 14;
    localparam int BANK_W              = 3;
    localparam logic [2:0] BANK_MR2    = 3'h2;
    localparam logic [2:0] BANK_MR3    = 3'h3;
    localparam int TERM_LSB            = 9;
    localparam int CWL_LSB             = 3;
    localparam int SRT_BIT             = 7;
    localparam int RETAIN_LSB          = 0;
    localparam int READOUT_EN_BIT      = 2;
    localparam logic [13:0] MR2_ZERO_MASK = 14'h3940;
    localparam logic [13:0] MR3_ZERO_MASK = 14'h3FF8;
    // ------------------------------------------------------------------
    // Field encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] TERM_OFF    = 2'h0;
    localparam logic [1:0] TERM_DIV4   = 2'h1;
    localparam logic [1:0] TERM_DIV2   = 2'h2;
    localparam logic [2:0] CWL_MAX_CODE = 3'h4;
    localparam logic [3:0] CWL_BASE    = 4'h5;
    localparam logic [13:0] MR2_RESET  = 14'h0000;
    localparam logic [13:0] MR3_RESET  = 14'h0000;
    localparam logic [15:0] READOUT_PATTERN = 16'h00FF;
    // ------------------------------------------------------------------
    // Software register map of the controller end
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_MR2     = 4'h0;
    localparam logic [3:0] REG_MR3     = 4'h4;
    localparam logic [3:0] REG_CTRL    = 4'h8;
    localparam logic [3:0] REG_STATUS  = 4'hC;
    localparam int CTRL_SEND2_BIT      = 0;
    localparam int CTRL_SEND3_BIT      = 1;
    localparam int CTRL_HOT_BIT        = 2;
    localparam int CTRL_DLLOFF_BIT     = 3;
    localparam int CTRL_SREF_BIT       = 4;
    localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
    // ------------------------------------------------------------------
    // Refresh timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ              = 25000000;
    localparam int REFI_NORMAL_NS      = 7800;
    localparam int REFI_HOT_NS         = 3900;
    localparam int REFI_NORMAL_CYC     = REFI_NORMAL_NS / (1000000000 / CLK_HZ);
    localparam int REFI_HOT_CYC        = REFI_HOT_NS / (1000000000 / CLK_HZ);
endpackage

// File: core/mode_link_if.sv
/*
 * Command/address link between the controller and the mode register end.
 * Assumes one shared clock; the testbench connects both modports.
 */
`timescale 1ns/1ps
interface mode_link_if;
    import mode_reg_pkg::*;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic              wr_level;
    logic              self_ref;
    logic              refresh;
    modport device_end (input cs_n, ras_n, cas_n, we_n, bank, addr, wr_level, self_ref,
                        refresh);
    modport ctrl_end   (output cs_n, ras_n, cas_n, we_n, bank, addr, wr_level, self_ref,
                        refresh);
endinterface

// File: core/mode_reg_device.sv
/*
 * Mode register two and three end of the memory device.
 * Assumes command pins are synchronous to CLK_IN and come from the controller.
 */
// Summary of operation
// R1: A10:A9 select write termination value.
// R2: Termination codes off, div4, div2, reserved.
// R3: Write termination switches without new mode-set.
// R4: Write termination applies even when nominal off.
// R5: Write leveling uses only nominal termination.
// R6: Controller zeroes reserved register two bits.
// R7: A5:A3 give write column latency.
// R8: Latencies are whole clock cycles only.
// R9: Total latency is added plus column latency.
// R10: Codes 0..4 mean 5..9; rest reserved.
// R11: Partial retention drops unselected banks in self-refresh.
// R12: Without self-refresh all data stays valid.
// R13: Bit 7 enables high temperature self-refresh rate.
// R14: Enabled option doubles self-refresh rate always.
// R15: Controller doubles refresh above 85 degrees.
// R16: Controller sets option before hot self-refresh.
// R17: Register two written with bank 010.
// R18: Register three written with bank 011.
// R19: Controller zeroes reserved register three bits.
// R20: Readout location ignored when readout disabled.
// R21: Enabled readout returns predefined training pattern.
// R22: Controller disables write termination in DLL-off.
`timescale 1ns/1ps
module mode_reg_device (
    input  wire logic                        CLK_IN,
    input  wire logic                        RST_IN,
    mode_link_if.device_end                  link,
    input  wire logic [2:0]                  ADDED_LATENCY_IN,
    input  wire logic [1:0]                  NOMINAL_TERM_IN,
    input  wire logic                        WRITE_ACTIVE_IN,
    output logic      [1:0]                  TERM_SEL_OUT,
    output logic      [4:0]                  TOTAL_WRITE_LATENCY_OUT,
    output logic      [7:0]                  RETAIN_BANKS_OUT,
    output logic                             DOUBLE_RATE_OUT,
    output logic                             READOUT_EN_OUT,
    output logic      [1:0]                  READOUT_LOC_OUT,
    output logic      [15:0]                 READOUT_DATA_OUT,
    output logic                             RESERVED_CODE_OUT
);
    import mode_reg_pkg::*;

    typedef struct packed {
        logic [13:0] mr2;
        logic [13:0] mr3;
        logic [1:0]  term;
        logic [4:0]  wl;
        logic [7:0]  retain;
        logic        dbl;
        logic        ro_en;
        logic [1:0]  ro_loc;
        logic [15:0] ro_data;
        logic        bad;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic   mode_set;
    logic [1:0] wr_term;

    // ------------------------------------------------------------------
    // Register capture and derived controls
    // ------------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        mode_set = !link.cs_n && !link.ras_n && !link.cas_n && !link.we_n;
        if (mode_set && link.bank == BANK_MR2) begin // R17
            s_d.mr2 = link.addr;
        end
        if (mode_set && link.bank == BANK_MR3) begin // R18
            s_d.mr3 = link.addr;
        end
        wr_term = s_d.mr2[TERM_LSB +: 2]; // R1
        // Termination follows the write strobe without any mode-set.
        if (link.wr_level) begin
            s_d.term = NOMINAL_TERM_IN; // R5
        end else if (WRITE_ACTIVE_IN && wr_term != TERM_OFF) begin
            s_d.term = wr_term; // R3 R4 R2
        end else begin
            s_d.term = NOMINAL_TERM_IN;
        end
        // Whole-cycle latency only: a plain integer sum.
        s_d.wl = 5'(ADDED_LATENCY_IN) + 5'(CWL_BASE) + 5'(s_d.mr2[CWL_LSB +: 3]); // R7 R8 R9 R10
        s_d.bad = (s_d.mr2[CWL_LSB +: 3] > CWL_MAX_CODE) || (wr_term == 2'h3); // R10 R2
        unique case (s_d.mr2[RETAIN_LSB +: 3])
            3'h0: s_d.retain = 8'hFF;
            3'h1: s_d.retain = 8'h0F;
            3'h2: s_d.retain = 8'h03;
            3'h3: s_d.retain = 8'h01;
            3'h4: s_d.retain = 8'hFC;
            3'h5: s_d.retain = 8'hF0;
            3'h6: s_d.retain = 8'hC0;
            3'h7: s_d.retain = 8'h80;
        endcase
        if (!link.self_ref) begin
            s_d.retain = 8'hFF; // R12
        end // R11
        s_d.dbl   = s_d.mr2[SRT_BIT]; // R13 R14
        s_d.ro_en = s_d.mr3[READOUT_EN_BIT];
        s_d.ro_loc  = s_d.ro_en ? s_d.mr3[1:0] : 2'h0; // R20
        s_d.ro_data = s_d.ro_en ? READOUT_PATTERN : 16'h0000; // R21
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign TERM_SEL_OUT            = s_q.term;
    assign TOTAL_WRITE_LATENCY_OUT = s_q.wl;
    assign RETAIN_BANKS_OUT        = s_q.retain;
    assign DOUBLE_RATE_OUT         = s_q.dbl;
    assign READOUT_EN_OUT          = s_q.ro_en;
    assign READOUT_LOC_OUT         = s_q.ro_loc;
    assign READOUT_DATA_OUT        = s_q.ro_data;
    assign RESERVED_CODE_OUT       = s_q.bad;
endmodule // mode_reg_device

// File: core/mode_reg_ctrl.sv
/*
 * Controller end: software registers over classic Wishbone, mode-set issue.
 * Assumes a classic single-cycle Wishbone master on CLK_IN.
 */
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module mode_reg_ctrl (
    input  wire logic         CLK_IN,
    input  wire logic         RST_IN,
    input  wire logic         WB_CYC_IN,
    input  wire logic         WB_STB_IN,
    input  wire logic         WB_WE_IN,
    input  wire logic [3:0]   WB_ADR_IN,
    input  wire logic [3:0]   WB_SEL_IN,
    input  wire logic [31:0]  WB_DAT_IN,
    output logic      [31:0]  WB_DAT_OUT,
    output logic              WB_ACK_OUT,
    mode_link_if.ctrl_end     link
);
    import mode_reg_pkg::*;

    typedef enum logic [1:0] {IDLE, ISSUE, HOLD} phase_t;

    typedef struct packed {
        logic [13:0] mr2;
        logic [13:0] mr3;
        logic [4:0]  ctrl;
        logic        ack;
        logic [31:0] rdat;
        logic        pend2;
        logic        pend3;
        phase_t      ph;
        logic        cmd;
        logic [2:0]  bank;
        logic [13:0] addr;
        logic [8:0]  rcnt;
        logic        rfsh;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic   req;

    // ------------------------------------------------------------------
    // Bus slave, mode-set sequencing and refresh pacing
    // ------------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.ack  = 1'b0;
        s_d.rfsh = 1'b0;
        req      = WB_CYC_IN && WB_STB_IN && !s_q.ack;
        if (req) begin
            s_d.ack = 1'b1;
            if (WB_WE_IN && WB_SEL_IN[0] && WB_SEL_IN[1]) begin
                unique case (WB_ADR_IN)
                    REG_MR2: s_d.mr2 = WB_DAT_IN[13:0] & ~MR2_ZERO_MASK; // R6
                    REG_MR3: s_d.mr3 = WB_DAT_IN[13:0] & ~MR3_ZERO_MASK; // R19
                    REG_CTRL: begin
                        s_d.ctrl  = WB_DAT_IN[4:0];
                        s_d.pend2 = s_q.pend2 | WB_DAT_IN[CTRL_SEND2_BIT];
                        s_d.pend3 = s_q.pend3 | WB_DAT_IN[CTRL_SEND3_BIT];
                    end
                    default: ;
                endcase
            end
            unique case (WB_ADR_IN)
                REG_MR2:    s_d.rdat = {18'h0, s_q.mr2};
                REG_MR3:    s_d.rdat = {18'h0, s_q.mr3};
                REG_CTRL:   s_d.rdat = {27'h0, s_q.ctrl};
                REG_STATUS: s_d.rdat = {29'h0, s_q.ph != IDLE, s_q.pend3, s_q.pend2};
                default:    s_d.rdat = UNMAPPED_VALUE;
            endcase
        end
        s_d.cmd = 1'b0;
        unique case (s_q.ph)
            IDLE: begin
                if (s_q.pend2) begin
                    s_d.bank = BANK_MR2; // R17
                    s_d.addr = s_q.mr2;
                    if (s_q.ctrl[CTRL_DLLOFF_BIT]) begin
                        s_d.addr[TERM_LSB +: 2] = TERM_OFF; // R22
                    end
                    if (s_q.ctrl[CTRL_HOT_BIT]) begin
                        s_d.addr[SRT_BIT] = 1'b1; // R16
                    end
                    s_d.pend2 = 1'b0;
                    s_d.cmd   = 1'b1;
                    s_d.ph    = ISSUE;
                end else if (s_q.pend3) begin
                    s_d.bank  = BANK_MR3; // R18
                    s_d.addr  = s_q.mr3;
                    s_d.pend3 = 1'b0;
                    s_d.cmd   = 1'b1;
                    s_d.ph    = ISSUE;
                end
            end
            ISSUE: s_d.ph = HOLD;
            HOLD:  s_d.ph = IDLE;
        endcase
        if (s_q.rcnt == 9'h000) begin
            s_d.rfsh = 1'b1;
            s_d.rcnt = s_q.ctrl[CTRL_HOT_BIT] ? 9'(REFI_HOT_CYC - 1)
                                               : 9'(REFI_NORMAL_CYC - 1); // R15
        end else begin
            s_d.rcnt = s_q.rcnt - 9'h001;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign WB_ACK_OUT    = s_q.ack;
    assign WB_DAT_OUT    = s_q.rdat;
    assign link.cs_n     = !s_q.cmd;
    assign link.ras_n    = !s_q.cmd;
    assign link.cas_n    = !s_q.cmd;
    assign link.we_n     = !s_q.cmd;
    assign link.bank     = s_q.bank;
    assign link.addr     = s_q.addr;
    assign link.wr_level = 1'b0;
    assign link.self_ref = s_q.ctrl[CTRL_SREF_BIT] &&
                           (s_q.mr2[SRT_BIT] || !s_q.ctrl[CTRL_HOT_BIT]); // R16
    assign link.refresh  = s_q.rfsh;
endmodule // mode_reg_ctrl

// File: bench/mode_reg_asserts.sv
/* Checker for the mode-set link between the two ends.
   Assumes the bench instantiates it beside the link, one clock. */
`timescale 1ns/1ps
module mode_reg_asserts
    import mode_reg_pkg::*;
(
    input wire logic              CLK_IN,
    input wire logic              RST_IN,
    input wire logic              cs_n,
    input wire logic              ras_n,
    input wire logic              cas_n,
    input wire logic              we_n,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              wr_level,
    input wire logic              self_ref,
    input wire logic              refresh
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    logic cmd;
    assign cmd = !cs_n && !ras_n && !cas_n && !we_n;
    sequence s_mr2;
        cmd && bank == BANK_MR2;
    endsequence
    sequence s_mr3;
        cmd && bank == BANK_MR3;
    endsequence
    property p_bank;
        !cs_n |-> cmd && (bank == BANK_MR2 || bank == BANK_MR3);
    endproperty
    a_bank: assert property (p_bank) else $error("bad mode-set");
    property p_mr2_zero;
        s_mr2 |-> (addr & MR2_ZERO_MASK) == 14'h0000;
    endproperty
    a_mr2_zero: assert property (p_mr2_zero) else $error("mr2 reserved set");
    property p_mr2_codes;
        s_mr2 |-> addr[10:9] != 2'h3 && addr[5:3] <= CWL_MAX_CODE;
    endproperty
    a_mr2_codes: assert property (p_mr2_codes) else $error("reserved code");
    property p_mr3_zero;
        s_mr3 |-> (addr & MR3_ZERO_MASK) == 14'h0000;
    endproperty
    a_mr3_zero: assert property (p_mr3_zero) else $error("mr3 reserved set");
    property p_spacing;
        cmd |=> !cmd [*2];
    endproperty
    a_spacing: assert property (p_spacing) else $error("commands too close");
    property p_hold;
        cmd |=> $stable(addr) && $stable(bank);
    endproperty
    a_hold: assert property (p_hold) else $error("address not held");
    property p_wrlvl;
        !wr_level;
    endproperty
    a_wrlvl: assert property (p_wrlvl) else $error("leveling raised");
    property p_ref_pulse;
        refresh |=> !refresh [*8];
    endproperty
    a_ref_pulse: assert property (p_ref_pulse) else $error("refresh too soon");
    property p_ref_due;
        refresh |-> ##[1:195] refresh;
    endproperty
    a_ref_due: assert property (p_ref_due) else $error("refresh late");
endmodule // mode_reg_asserts

// File: bench/testbench.sv
/* Bench for both ends joined by the link.
   Assumes the package constants and the hand-over timing. */
`timescale 1ns/1ps
module testbench;
    import mode_reg_pkg::*;
    logic        clk, rst, cyc, stb, we, ack, wrt, dbl, ren, bad;
    logic [3:0]  adr, sel;
    logic [31:0] dw, dr, q;
    logic [2:0]  al;
    logic [1:0]  nom, term, rloc;
    logic [4:0]  wl;
    logic [7:0]  ret;
    logic [15:0] rdat;
    logic [13:0] f;
    logic [7:0]  map [8] = '{8'hFF, 8'h0F, 8'h03, 8'h01, 8'hFC, 8'hF0, 8'hC0, 8'h80};
    int          err_count, n_checks, i;
    mode_link_if link ();
    mode_reg_ctrl i_mode_reg_ctrl (.CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
        .WB_DAT_IN(dw), .WB_DAT_OUT(dr), .WB_ACK_OUT(ack), .link(link.ctrl_end));
    mode_reg_device i_mode_reg_device (.CLK_IN(clk), .RST_IN(rst), .link(link.device_end),
        .ADDED_LATENCY_IN(al), .NOMINAL_TERM_IN(nom), .WRITE_ACTIVE_IN(wrt),
        .TERM_SEL_OUT(term), .TOTAL_WRITE_LATENCY_OUT(wl), .RETAIN_BANKS_OUT(ret),
        .DOUBLE_RATE_OUT(dbl), .READOUT_EN_OUT(ren), .READOUT_LOC_OUT(rloc),
        .READOUT_DATA_OUT(rdat), .RESERVED_CODE_OUT(bad));
    mode_reg_asserts i_mode_reg_asserts (.CLK_IN(clk), .RST_IN(rst), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .bank(link.bank),
        .addr(link.addr), .wr_level(link.wr_level), .self_ref(link.self_ref),
        .refresh(link.refresh));
    // ----------------------------------------------------------------
    // Bus, check and refresh-gap tasks
    // ----------------------------------------------------------------
    task wrap_up;
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dw  <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dr;
        if (n >= 50) begin
            err_count++;
            $display("[FAIL] %0t no bus answer", $time);
            wrap_up();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task send(input logic [3:0] a, input logic [13:0] v, input logic [31:0] c);
        int n;
        wb(1'b1, a, {18'h0, v});
        wb(1'b1, REG_CTRL, c | (32'h1 << (a == REG_MR2 ? CTRL_SEND2_BIT : CTRL_SEND3_BIT)));
        n = 0;
        do begin
            wb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (q[2:0] !== 3'h0 && n < 20);
        if (n >= 20) begin
            err_count++;
            $display("[FAIL] %0t mode-set never completed", $time);
            wrap_up();
        end
        repeat (3) @(posedge clk);
    endtask
    task gap(input int e);
        int n;
        n = 0;
        while (link.refresh !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (link.refresh !== 1'b1 && n < 400);
        chk(n, e);
        if (n >= 400)
            wrap_up();
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst, wrt} = 2'h3;
        {cyc, stb, we, adr, dw, al, nom} = '0;
        sel = 4'hF;
        err_count = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk(dbl, 0);
        for (i = 0; i < 5; i++) begin
            al <= 3'(i);
            nom <= 2'(i);
            f = 14'(i << CWL_LSB) | 14'((i % 3) << TERM_LSB) | 14'((i & 1) << SRT_BIT);
            send(REG_MR2, f | MR2_ZERO_MASK, 32'h0);
            chk(wl, 2 * i + CWL_BASE);
            chk(bad, 0);
            chk(term, (i % 3 != 0) ? i % 3 : i & 3);
            chk(dbl, i & 1);
            wrt <= 1'b0;
            repeat (2) @(posedge clk);
            chk(term, i & 3);
            wrt <= 1'b1;
            wb(1'b0, REG_MR2, 32'h0);
            chk(q, {18'h0, f});
        end
        send(REG_MR3, 14'h3FFB, 32'h0);
        chk({ren, rloc, rdat}, 32'h0);
        send(REG_MR3, 14'h0006, 32'h0);
        chk({ren, rloc, rdat}, {13'h0, 3'h6, READOUT_PATTERN});
        wb(1'b0, REG_MR3, 32'h0);
        chk(q, 32'h6);
        for (i = 0; i < 8; i++) begin
            send(REG_MR2, 14'(i), 32'h0);
            chk(ret, 8'hFF);
            wb(1'b1, REG_CTRL, 32'h1 << CTRL_SREF_BIT);
            repeat (3) @(posedge clk);
            chk(ret, map[i]);
            wb(1'b1, REG_CTRL, 32'h0);
        end
        gap(REFI_NORMAL_CYC);
        nom <= 2'h2;
        send(REG_MR2, 14'(1 << TERM_LSB), (32'h1 << CTRL_HOT_BIT) | (32'h1 << CTRL_DLLOFF_BIT));
        chk(dbl, 1);
        chk(term, 2);
        gap(REFI_HOT_CYC);
        wb(1'b0, 4'h2, 32'h0);
        chk(q, UNMAPPED_VALUE);
        wrap_up();
    end
endmodule // testbench
